// ---- hdl/ach_auth_core.v ----
// Authentication command handler with AHB-Lite control registers
//
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "ach_defs.vh"
// Behaviour
// - Command frame 01, 00 04, 30, fields, 03
// - Missing end byte answers packet error
// - Checksum mismatch answers checksum error
// - Bad or wrong length answers packet error
// - Any error abandons command, waits again
// - Disallowed lifecycle state gives acceptance error
// - Encrypted write without reset: acceptance error
// - Active versus stored state mismatch error
// - Source must equal current state or level
// - Only permitted source/destination pairs accepted
// - Disabled key for destination: protection error
// - Unique ID only towards return request
// - Send 16-byte challenge packet, MSB first
// - Challenge failure sends trusted system error
// - Security fault after challenge: go silent
// - Discard bytes until data start byte
// - Response checks: end, checksum, length
// - Wrong response code or length: packet error
// - Success status packet with checksum CE
// - Error status packet with code B0
// - Highest priority error; unused fields all-ones
module ach_auth_core #(
  parameter CHAL_BYTES = 16,
  parameter RESP_BYTES = 32
) (
  // Clock, reset, enable
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Serial byte stream
  input wire rx_valid,
  input wire [7:0] rx_data,
  output wire tx_valid,
  output wire [7:0] tx_data,
  input wire tx_ready,
  // Challenge source
  output reg chal_req,
  output reg chal_uid,
  input wire chal_done,
  input wire chal_fail,
  input wire [8*CHAL_BYTES-1:0] chal_value,
  input wire sec_abnormal,
  // Verification stage
  output reg verify_start,
  output reg [8*RESP_BYTES-1:0] verify_value,
  input wire verify_done,
  input wire verify_ok,
  // Status
  output reg halted
);
  localparam S_CMD = 3'd0;
  localparam S_CHREQ = 3'd1;
  localparam S_CHWAIT = 3'd2;
  localparam S_SEND = 3'd3;
  localparam S_RESP = 3'd4;
  localparam S_VERIFY = 3'd5;
  localparam S_HALT = 3'd6;

  reg [2:0] st_r;
  reg [1:0] ctrl_r;
  reg [23:0] state_r;
  reg enc_seen_r;
  reg [7:0] last_sts_r;
  reg wr_pend_r;
  reg [7:0] wadr_r;
  reg [7:0] code_r;
  reg [7:0] src_r;
  reg [7:0] dst_r;
  reg [7:0] type_r;
  reg tx_start_r;
  reg tx_chal_r;
  reg [7:0] tx_code_r;
  reg [7:0] tx_sts_r;
  reg [127:0] tx_val_r;
  reg after_chal_r;
  reg [31:0] rd_mux;
  reg [7:0] cmd_err;
  reg cmd_ign;
  reg [7:0] rsp_err;

  wire pay_valid;
  wire [5:0] pay_idx;
  wire [7:0] pay_byte;
  wire frame_done;
  wire end_bad;
  wire sum_bad;
  wire len_bad;
  wire [15:0] len;
  wire tx_busy;
  wire rx_armed;
  wire [7:0] rx_start;
  wire tx_abort;
  wire [7:0] lc_active;
  wire [7:0] lc_stored;
  wire [7:0] auth_level;
  wire is_lc;
  wire pair_ok;
  wire protect;
  wire type_ok;
  wire [7:0] cur_src;
  wire bus_req;

  assign lc_active = state_r[7:0];
  assign lc_stored = state_r[15:8];
  assign auth_level = state_r[23:16];
  // Flow control by the clock enable: a frozen block must stall the bus
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign bus_req = hsel && htrans[1] && hready;

  assign rx_armed = (st_r == S_CMD) || (st_r == S_RESP);
  assign rx_start = (st_r == S_RESP) ? `ACH_DATA_START : `ACH_CMD_START;
  assign tx_abort = after_chal_r && sec_abnormal &&
                    (st_r == S_SEND);

  ach_pkt_rx #(.MAX_BODY(RESP_BYTES + 1)) u_rx (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .armed(rx_armed),
    .start_byte(rx_start),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .pay_valid(pay_valid),
    .pay_idx(pay_idx),
    .pay_byte(pay_byte),
    .frame_done(frame_done),
    .end_bad(end_bad),
    .sum_bad(sum_bad),
    .len_bad(len_bad),
    .len(len)
  );

  ach_pkt_tx u_tx (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .start(tx_start_r),
    .abort(tx_abort),
    .is_chal(tx_chal_r),
    .code(tx_code_r),
    .sts(tx_sts_r),
    .value(tx_val_r),
    .busy(tx_busy),
    .tx_valid(tx_valid),
    .tx_data(tx_data),
    .tx_ready(tx_ready)
  );

  // Command parameter analysis
  assign is_lc = (dst_r == `ACH_LC_RET_REQ) || (dst_r == `ACH_LC_RET_ACK);
  assign cur_src = is_lc ? lc_active : auth_level;
  assign pair_ok = is_lc ?
    ((src_r == `ACH_LC_OWNED && dst_r == `ACH_LC_RET_REQ) ||
     (src_r == `ACH_LC_RET_REQ && dst_r == `ACH_LC_RET_ACK)) :
    ((src_r == `ACH_AL_ONE && dst_r == `ACH_AL_TWO) ||
     (src_r == `ACH_AL_ZERO && dst_r == `ACH_AL_TWO) ||
     (src_r == `ACH_AL_ZERO && dst_r == `ACH_AL_ONE));
  assign protect =
    (!ctrl_r[`ACH_CTRL_L2] &&
     ((is_lc && dst_r == `ACH_LC_RET_REQ) ||
      (!is_lc && dst_r == `ACH_AL_TWO))) ||
    (!ctrl_r[`ACH_CTRL_L1] && !is_lc && dst_r == `ACH_AL_ONE);
  assign type_ok = (type_r == `ACH_CHAL_RANDOM) ||
    (type_r == `ACH_CHAL_UID && is_lc &&
     dst_r == `ACH_LC_RET_REQ);

  // Error codes in descending priority
  always @* begin
    cmd_ign = 1'b0;
    if (end_bad)
      cmd_err = `ACH_ST_PACKET;
    else if (sum_bad)
      cmd_err = `ACH_ST_CHECKSUM;
    else if (len_bad || len != `ACH_CMD_LEN)
      cmd_err = `ACH_ST_PACKET;
    else if (code_r != `ACH_CODE_AUTH) begin
      cmd_err = `ACH_ST_OK;
      cmd_ign = 1'b1;
    end else if (lc_active != `ACH_LC_OWNED &&
                 lc_active != `ACH_LC_RET_REQ)
      cmd_err = `ACH_ST_ACCEPT;
    else if (enc_seen_r)
      cmd_err = `ACH_ST_ACCEPT;
    else if (lc_active != lc_stored)
      cmd_err = `ACH_ST_UNMATCHED;
    else if (src_r != cur_src)
      cmd_err = `ACH_ST_PARAM;
    else if (!pair_ok)
      cmd_err = `ACH_ST_PARAM;
    else if (protect)
      cmd_err = `ACH_ST_PROTECT;
    else if (!type_ok)
      cmd_err = `ACH_ST_PARAM;
    else
      cmd_err = `ACH_ST_OK;
  end

  always @* begin
    if (end_bad)
      rsp_err = `ACH_ST_PACKET;
    else if (sum_bad)
      rsp_err = `ACH_ST_CHECKSUM;
    else if (len_bad)
      rsp_err = `ACH_ST_PACKET;
    else if (code_r != `ACH_CODE_AUTH)
      rsp_err = `ACH_ST_PACKET;
    else if (len != `ACH_RESP_LEN)
      rsp_err = `ACH_ST_PACKET;
    else
      rsp_err = `ACH_ST_OK;
  end

  always @* begin
    case (haddr[7:0])
      `ACH_REG_CTRL: rd_mux = {30'h0, ctrl_r};
      `ACH_REG_STATE: rd_mux = {8'h00, state_r};
      `ACH_REG_ENCW: rd_mux = {31'h0, enc_seen_r};
      `ACH_REG_STATUS: rd_mux = {19'h0, halted, 1'b0, st_r, last_sts_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Register slave: address phase latched, write in data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wadr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      ctrl_r <= `ACH_CTRL_RST;
      state_r <= `ACH_STATE_RST;
      enc_seen_r <= 1'b0;
    end else if (ce) begin
      wr_pend_r <= bus_req && hwrite;
      if (bus_req) begin
        wadr_r <= haddr[7:0];
        hrdata <= rd_mux;
      end
      if (wr_pend_r) begin
        case (wadr_r)
          `ACH_REG_CTRL: ctrl_r <= hwdata[1:0];
          `ACH_REG_STATE: state_r <= hwdata[23:0];
          // Sticky until device reset
          `ACH_REG_ENCW: enc_seen_r <= enc_seen_r | hwdata[0];
          default: enc_seen_r <= enc_seen_r;
        endcase
      end
    end
  end

  // Capture of received fields
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      code_r <= 8'h00;
      src_r <= 8'h00;
      dst_r <= 8'h00;
      type_r <= 8'h00;
      verify_value <= {8*RESP_BYTES{1'b0}};
    end else if (ce && pay_valid) begin
      if (pay_idx == 6'd0)
        code_r <= pay_byte;
      if (st_r == S_RESP && pay_idx != 6'd0)
        verify_value <= {verify_value[8*RESP_BYTES-9:0], pay_byte};
      if (st_r == S_CMD) begin
        if (pay_idx == 6'd1)
          src_r <= pay_byte;
        if (pay_idx == 6'd2)
          dst_r <= pay_byte;
        if (pay_idx == 6'd3)
          type_r <= pay_byte;
      end
    end
  end

  // Sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= S_CMD;
      tx_start_r <= 1'b0;
      tx_chal_r <= 1'b0;
      tx_code_r <= 8'h00;
      tx_sts_r <= 8'h00;
      tx_val_r <= 128'h0;
      after_chal_r <= 1'b0;
      last_sts_r <= 8'h00;
      chal_req <= 1'b0;
      chal_uid <= 1'b0;
      verify_start <= 1'b0;
      halted <= 1'b0;
    end else if (ce) begin
      tx_start_r <= 1'b0;
      chal_req <= 1'b0;
      verify_start <= 1'b0;
      if (after_chal_r && sec_abnormal && st_r != S_HALT) begin
        st_r <= S_HALT;
        halted <= 1'b1;
      end else begin
        case (st_r)
          S_CMD: begin
            if (frame_done && !cmd_ign) begin
              if (cmd_err != `ACH_ST_OK) begin
                tx_start_r <= 1'b1;
                tx_chal_r <= 1'b0;
                tx_code_r <= `ACH_CODE_ERR;
                tx_sts_r <= cmd_err;
                last_sts_r <= cmd_err;
                st_r <= S_SEND;
              end else begin
                chal_req <= 1'b1;
                chal_uid <= type_r == `ACH_CHAL_UID;
                st_r <= S_CHREQ;
              end
            end
          end
          S_CHREQ: st_r <= S_CHWAIT;
          S_CHWAIT: begin
            if (chal_done) begin
              tx_start_r <= 1'b1;
              if (chal_fail) begin
                tx_chal_r <= 1'b0;
                tx_code_r <= `ACH_CODE_ERR;
                tx_sts_r <= `ACH_ST_TRUSTED;
                last_sts_r <= `ACH_ST_TRUSTED;
              end else begin
                tx_chal_r <= 1'b1;
                tx_code_r <= `ACH_CODE_AUTH;
                tx_val_r <= chal_value;
                after_chal_r <= 1'b1;
              end
              st_r <= S_SEND;
            end
          end
          S_SEND: begin
            if (!tx_start_r && !tx_busy)
              st_r <= tx_chal_r ? S_RESP : S_CMD;
          end
          S_RESP: begin
            if (frame_done) begin
              if (rsp_err != `ACH_ST_OK) begin
                tx_start_r <= 1'b1;
                tx_chal_r <= 1'b0;
                tx_code_r <= `ACH_CODE_ERR;
                tx_sts_r <= rsp_err;
                last_sts_r <= rsp_err;
                after_chal_r <= 1'b0;
                st_r <= S_SEND;
              end else begin
                verify_start <= 1'b1;
                st_r <= S_VERIFY;
              end
            end
          end
          S_VERIFY: begin
            if (verify_done) begin
              tx_start_r <= 1'b1;
              tx_chal_r <= 1'b0;
              after_chal_r <= 1'b0;
              tx_code_r <= verify_ok ? `ACH_CODE_AUTH : `ACH_CODE_ERR;
              tx_sts_r <= verify_ok ? `ACH_ST_OK : `ACH_ST_TRUSTED;
              last_sts_r <= verify_ok ? `ACH_ST_OK : `ACH_ST_TRUSTED;
              st_r <= S_SEND;
            end
          end
          S_HALT: st_r <= S_HALT;
          default: st_r <= S_CMD;
        endcase
      end
    end
  end
endmodule

// ---- hdl/ach_pkt_rx.v ----
// Packet receiver: framing, length and checksum checks
`timescale 1ns/10ps
`include "ach_defs.vh"
module ach_pkt_rx #(
  parameter MAX_BODY = 33
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // Control
  input wire armed,
  input wire [7:0] start_byte,
  // Byte stream
  input wire rx_valid,
  input wire [7:0] rx_data,
  // Results
  output reg pay_valid,
  output reg [5:0] pay_idx,
  output reg [7:0] pay_byte,
  output reg frame_done,
  output reg end_bad,
  output reg sum_bad,
  output reg len_bad,
  output reg [15:0] len
);
  localparam HUNT = 3'd0;
  localparam LENH = 3'd1;
  localparam LENL = 3'd2;
  localparam BODY = 3'd3;
  localparam SUMB = 3'd4;
  localparam ENDB = 3'd5;
  reg [2:0] st_r;
  reg [7:0] sum_r;
  reg [15:0] cnt_r;
  wire [15:0] len_nxt;
  assign len_nxt = {len[15:8], rx_data};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= HUNT;
      sum_r <= 8'h00;
      cnt_r <= 16'h0000;
      pay_valid <= 1'b0;
      pay_idx <= 6'h00;
      pay_byte <= 8'h00;
      frame_done <= 1'b0;
      end_bad <= 1'b0;
      sum_bad <= 1'b0;
      len_bad <= 1'b0;
      len <= 16'h0000;
    end else if (ce) begin
      pay_valid <= 1'b0;
      frame_done <= 1'b0;
      if (!armed) begin
        st_r <= HUNT;
      end else if (rx_valid) begin
        case (st_r)
          HUNT: begin
            if (rx_data == start_byte) begin
              st_r <= LENH;
              sum_r <= 8'h00;
            end
          end
          LENH: begin
            len <= {rx_data, 8'h00};
            sum_r <= rx_data;
            st_r <= LENH + 3'd1;
          end
          LENL: begin
            len <= len_nxt;
            sum_r <= sum_r + rx_data;
            cnt_r <= 16'h0000;
            len_bad <= (len_nxt == 16'h0000) || (len_nxt > MAX_BODY);
            st_r <= (len_nxt == 16'h0000) ? SUMB : BODY;
          end
          BODY: begin
            sum_r <= sum_r + rx_data;
            if (cnt_r < MAX_BODY) begin
              pay_valid <= 1'b1;
              pay_idx <= cnt_r[5:0];
              pay_byte <= rx_data;
            end
            cnt_r <= cnt_r + 16'h0001;
            if (cnt_r == len - 16'h0001)
              st_r <= SUMB;
          end
          SUMB: begin
            sum_bad <= (sum_r + rx_data) != 8'h00;
            st_r <= ENDB;
          end
          ENDB: begin
            end_bad <= rx_data != `ACH_END_BYTE;
            frame_done <= 1'b1;
            st_r <= HUNT;
          end
          default: st_r <= HUNT;
        endcase
      end
    end
  end
endmodule

// ---- hdl/ach_pkt_tx.v ----
// Packet sender: challenge data packet and status packets
`timescale 1ns/10ps
`include "ach_defs.vh"
module ach_pkt_tx (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // Request
  input wire start,
  input wire abort,
  input wire is_chal,
  input wire [7:0] code,
  input wire [7:0] sts,
  input wire [127:0] value,
  output reg busy,
  // Byte stream
  output reg tx_valid,
  output reg [7:0] tx_data,
  input wire tx_ready
);
  reg [4:0] idx_r;
  reg [7:0] sum_r;
  reg chal_r;
  reg [7:0] code_r;
  reg [7:0] sts_r;
  reg [127:0] val_r;
  reg [7:0] nb;
  reg [7:0] sum_n;
  wire [4:0] last;
  wire [4:0] nidx;
  assign last = chal_r ? 5'd21 : 5'd14;
  assign nidx = idx_r + 5'd1;
  always @* begin
    sum_n = (idx_r == 5'd0) ? 8'h00 : sum_r + tx_data;
    if (nidx == 5'd1)
      nb = 8'h00;
    else if (nidx == 5'd2)
      nb = chal_r ? `ACH_CHAL_LEN : `ACH_STAT_LEN;
    else if (nidx == 5'd3)
      nb = code_r;
    else if (nidx == last - 5'd1)
      nb = 8'h00 - sum_n;
    else if (nidx == last)
      nb = `ACH_END_BYTE;
    else if (chal_r)
      nb = val_r[127:120];
    else if (nidx == 5'd4)
      nb = sts_r;
    else
      nb = `ACH_UNUSED_BYTE;
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_r <= 5'd0;
      sum_r <= 8'h00;
      chal_r <= 1'b0;
      code_r <= 8'h00;
      sts_r <= 8'h00;
      val_r <= 128'h0;
      busy <= 1'b0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end else if (ce) begin
      if (abort) begin
        busy <= 1'b0;
        tx_valid <= 1'b0;
      end else if (start && !busy) begin
        busy <= 1'b1;
        tx_valid <= 1'b1;
        tx_data <= `ACH_DATA_START;
        idx_r <= 5'd0;
        chal_r <= is_chal;
        code_r <= code;
        sts_r <= sts;
        val_r <= value;
      end else if (tx_valid && tx_ready) begin
        if (idx_r == last) begin
          tx_valid <= 1'b0;
          busy <= 1'b0;
        end else begin
          idx_r <= nidx;
          sum_r <= sum_n;
          tx_data <= nb;
          if (chal_r && nidx >= 5'd4 && nidx < 5'd20)
            val_r <= {val_r[119:0], 8'h00};
        end
      end
    end
  end
endmodule

// ---- include/ach_defs.vh ----
// Constants for the authentication command handler
`ifndef ACH_DEFS_VH
`define ACH_DEFS_VH
`define ACH_CMD_START 8'h01
`define ACH_DATA_START 8'h81
`define ACH_END_BYTE 8'h03
`define ACH_CODE_AUTH 8'h30
`define ACH_CODE_ERR 8'hB0
`define ACH_CMD_LEN 16'h0004
`define ACH_RESP_LEN 16'h0021
`define ACH_CHAL_LEN 8'h11
`define ACH_STAT_LEN 8'h0A
`define ACH_OK_SUM 8'hCE
`define ACH_UNUSED_BYTE 8'hFF
`define ACH_ST_OK 8'h00
`define ACH_ST_PACKET 8'hC1
`define ACH_ST_CHECKSUM 8'hC2
`define ACH_ST_ACCEPT 8'hC3
`define ACH_ST_UNMATCHED 8'hC4
`define ACH_ST_PARAM 8'hC5
`define ACH_ST_PROTECT 8'hC6
`define ACH_ST_TRUSTED 8'hC7
`define ACH_LC_OWNED 8'h04
`define ACH_LC_RET_REQ 8'h07
`define ACH_LC_RET_ACK 8'h08
`define ACH_AL_TWO 8'h02
`define ACH_AL_ONE 8'h03
`define ACH_AL_ZERO 8'h04
`define ACH_CHAL_RANDOM 8'h00
`define ACH_CHAL_UID 8'h01
`define ACH_REG_CTRL 8'h00
`define ACH_REG_STATE 8'h04
`define ACH_REG_ENCW 8'h08
`define ACH_REG_STATUS 8'h0C
`define ACH_CTRL_L2 0
`define ACH_CTRL_L1 1
`define ACH_CTRL_RST 2'h3
`define ACH_STATE_RST 24'h040404
`endif

// ---- testbench/ach_auth_core_properties.sv ----
// Checker for the handshakes and packet timing of the command handler
`timescale 1ns/10ps
module ach_core_props (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Serial byte stream
  input wire tx_valid,
  input wire [7:0] tx_data,
  input wire tx_ready,
  // Challenge and verification handshakes
  input wire chal_req,
  input wire chal_done,
  input wire chal_fail,
  input wire sec_abnormal,
  input wire verify_start,
  input wire halted
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("tx byte changed before taken");
  property p_pkt_start;
    $rose(tx_valid) |-> tx_data == 8'h81;
  endproperty
  a_pkt_start: assert property (p_pkt_start)
    else $error("packet does not open with data start");
  // A good or failed challenge must both answer within one to four cycles
  property p_chal_ans;
    chal_done && !sec_abnormal |-> ##[1:4] (tx_valid && tx_data == 8'h81);
  endproperty
  a_chal_ans: assert property (p_chal_ans)
    else $error("no packet after challenge");
  property p_silent;
    halted |-> !tx_valid;
  endproperty
  a_silent: assert property (p_silent)
    else $error("halted block still sends");
  property p_halt_sticky;
    halted |=> halted;
  endproperty
  a_halt_sticky: assert property (p_halt_sticky)
    else $error("halt left without reset");
  property p_chal_pulse;
    chal_req |=> !chal_req;
  endproperty
  a_chal_pulse: assert property (p_chal_pulse)
    else $error("challenge request longer than a pulse");
  property p_ver_quiet;
    verify_start |=> (!verify_start && !tx_valid && !chal_req) [*3];
  endproperty
  a_ver_quiet: assert property (p_ver_quiet)
    else $error("activity while verifying");
  property p_req_idle;
    chal_req |-> !tx_valid && !halted;
  endproperty
  a_req_idle: assert property (p_req_idle)
    else $error("challenge asked while sending");
  c_halt: cover property ($rose(halted));
  c_verify: cover property (verify_start);
  c_fail: cover property (chal_done && chal_fail);
endmodule
bind ach_auth_core ach_core_props u_props (.hclk(hclk),
  .hresetn(hresetn), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_ready(tx_ready), .chal_req(chal_req), .chal_done(chal_done),
  .chal_fail(chal_fail), .sec_abnormal(sec_abnormal),
  .verify_start(verify_start), .halted(halted));

// ---- testbench/ach_auth_core_test.sv ----
// Self-checking bench for the authentication command handler
`timescale 1ns/10ps
module ach_auth_core_test;
  typedef logic [7:0] ach_bq[$];
  localparam logic [127:0] chal_pat = 128'h0123456789ABCDEF1122334455667788;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic hreadyout, hresp, rx_valid, tx_valid, tx_ready, chal_req, chal_uid;
  logic [7:0] rx_data, tx_data;
  logic chal_done = 0, chal_fail = 0, sec_abnormal = 0, verify_start;
  logic verify_done = 0, verify_ok = 0, halted;
  logic [127:0] chal_value = 0;
  logic [255:0] verify_value;
  int mismatches = 0, cmp_count = 0;
  always #12.5 hclk = ~hclk;
  ach_auth_core u_dut (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .chal_req(chal_req),
    .chal_uid(chal_uid), .chal_done(chal_done), .chal_fail(chal_fail),
    .chal_value(chal_value), .sec_abnormal(sec_abnormal),
    .verify_start(verify_start), .verify_value(verify_value),
    .verify_done(verify_done), .verify_ok(verify_ok), .halted(halted));
  ach_host_model u_host (.hclk(hclk), .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(string what, logic [255:0] seen, logic [255:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic expire(string what);
    mismatches++;
    $display("wrong value %s expected response seen timeout", what);
    final_report();
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    for (int n = 0; n < lim; n++) begin
      @(posedge hclk);
      if (s === 1'b1) return;
    end
    expire("handshake");
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    wait_hi(hreadyout, 20);
    htrans <= 2'h0;
    hwdata <= wd;
    wait_hi(hreadyout, 20);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask
  task automatic expect_pkt(input ach_bq e, input string what);
    int n;
    for (n = 0; n < 2000 && u_host.got.size() < e.size(); n++)
      @(posedge hclk);
    if (n == 2000) expire(what);
    repeat (4) @(posedge hclk);
    check(what, u_host.got.size(), e.size());
    foreach (e[i]) check(what, u_host.got[i], e[i]);
    u_host.got.delete();
  endtask
  function automatic ach_bq err_pkt(input logic [7:0] sts);
    ach_bq b;
    b = {sts};
    repeat (8) b.push_back(8'hFF);
    return u_host.frame(8'h81, 8'hB0, b);
  endfunction
  task automatic cmd(input logic [7:0] s, d, t);
    u_host.send(u_host.frame(8'h01, 8'h30, {s, d, t}));
  endtask
  task automatic give_chal(input logic fail, uid, bad);
    wait_hi(chal_req, 200);
    check("unique id select", chal_uid, uid);
    repeat (3) @(posedge hclk);
    chal_value <= chal_pat;
    chal_fail <= fail;
    sec_abnormal <= bad;
    chal_done <= 1'b1;
    @(posedge hclk);
    chal_done <= 1'b0;
  endtask
  task automatic t_regs();
    logic [31:0] v;
    logic [7:0] a[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [31:0] e[5] = '{32'h3, 32'h040404, 32'h0, 32'h0, 32'h0};
    foreach (a[i]) begin
      ahb(1'b0, a[i], 32'h0, v);
      check("register", v, e[i]);
    end
  endtask
  task automatic t_frame();
    ach_bq f;
    logic [31:0] v;
    f = u_host.frame(8'h01, 8'h30, {8'h04, 8'h07, 8'h00});
    f[7] = f[7] ^ 8'h01;
    u_host.send({8'h55, 8'h81, f});
    expect_pkt(err_pkt(8'hC2), "sum error");
    ahb(1'b0, 8'h0C, 32'h0, v);
    check("last status", v[7:0], 8'hC2);
    f[8] = 8'h55;
    u_host.send(f);
    expect_pkt(err_pkt(8'hC1), "no end byte");
    u_host.send(u_host.frame(8'h01, 8'h30, {8'h04, 8'h07, 8'h00, 8'h00}));
    expect_pkt(err_pkt(8'hC1), "length");
  endtask
  // Key enables, state, source, destination, type, expected status
  task automatic t_table();
    logic [63:0] tc[9] = '{64'h03_040408_04_07_00_C3,
      64'h03_040704_04_07_00_C4, 64'h03_040404_07_08_00_C5,
      64'h03_040404_03_02_00_C5, 64'h03_040404_04_08_00_C5,
      64'h00_040404_04_07_00_C6, 64'h01_040404_04_03_00_C6,
      64'h03_040404_04_02_01_C5, 64'h03_040404_04_07_02_C5};
    foreach (tc[i]) begin
      wr(8'h00, {24'h0, tc[i][63:56]});
      wr(8'h04, {8'h0, tc[i][55:32]});
      cmd(tc[i][31:24], tc[i][23:16], tc[i][15:8]);
      expect_pkt(err_pkt(tc[i][7:0]), "parameter");
    end
  endtask
  task automatic t_encw();
    wr(8'h00, 32'h3);
    wr(8'h04, 32'h040404);
    wr(8'h08, 32'h1);
    cmd(8'h04, 8'h07, 8'h00);
    expect_pkt(err_pkt(8'hC3), "encrypted write");
    do_reset();
  endtask
  task automatic t_ok();
    ach_bq c, r, e;
    logic [255:0] rv;
    for (int i = 15; i >= 0; i--) c.push_back(chal_pat[8*i +: 8]);
    for (int i = 0; i < 32; i++) r.push_back(8'hA0 ^ 8'(i));
    foreach (r[i]) rv[255 - 8*i -: 8] = r[i];
    e = {8'h81, 8'h00, 8'h0A, 8'h30, 8'h00};
    repeat (8) e.push_back(8'hFF);
    e = {e, 8'hCE, 8'h03};
    u_host.slow = 1'b1;
    cmd(8'h04, 8'h07, 8'h01);
    give_chal(1'b0, 1'b1, 1'b0);
    expect_pkt(u_host.frame(8'h81, 8'h30, c), "challenge");
    u_host.send({8'h01, 8'h30, u_host.frame(8'h81, 8'h30, r)});
    wait_hi(verify_start, 200);
    check("verify value", verify_value, rv);
    repeat (5) @(posedge hclk);
    verify_ok <= 1'b1;
    verify_done <= 1'b1;
    @(posedge hclk);
    verify_done <= 1'b0;
    expect_pkt(e, "success");
    u_host.slow = 1'b0;
  endtask
  task automatic t_fail();
    cmd(8'h04, 8'h03, 8'h00);
    give_chal(1'b1, 1'b0, 1'b0);
    expect_pkt(err_pkt(8'hC7), "challenge failure");
  endtask
  // Wrong code, short body, then a bad sum in the reply
  task automatic t_resp();
    ach_bq r, f;
    for (int k = 0; k < 3; k++) begin
      r = {};
      repeat (k == 1 ? 31 : 32) r.push_back(8'h5A);
      cmd(8'h04, 8'h02, 8'h00);
      give_chal(1'b0, 1'b0, 1'b0);
      repeat (60) @(posedge hclk);
      u_host.got.delete();
      f = u_host.frame(8'h81, k == 0 ? 8'h31 : 8'h30, r);
      if (k == 2) f[36] = f[36] ^ 8'h01;
      u_host.send(f);
      expect_pkt(err_pkt(k == 2 ? 8'hC2 : 8'hC1), "reply");
    end
  endtask
  task automatic t_halt();
    cmd(8'h04, 8'h07, 8'h00);
    give_chal(1'b0, 1'b0, 1'b1);
    repeat (40) @(posedge hclk);
    check("halted", halted, 1'b1);
    cmd(8'h04, 8'h07, 8'h00);
    repeat (40) @(posedge hclk);
    check("bytes after fault", u_host.got.size(), 0);
    sec_abnormal <= 1'b0;
    do_reset();
    check("halted after reset", halted, 1'b0);
  endtask
  initial begin
    do_reset();
    t_regs();
    t_frame();
    t_table();
    t_encw();
    t_ok();
    t_fail();
    t_resp();
    t_halt();
    final_report();
  end
endmodule

// ---- testbench/ach_host_model.sv ----
// Host model: builds and sends frames, collects device packets
`timescale 1ns/10ps
module ach_host_model (
  // Clock
  input wire hclk,
  // Bytes towards the device
  output logic rx_valid,
  output logic [7:0] rx_data,
  // Bytes from the device
  input wire tx_valid,
  input wire [7:0] tx_data,
  output logic tx_ready
);
  typedef logic [7:0] ach_bq[$];
  logic [7:0] got[$];
  logic slow = 1'b0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  // Slow mode drops ready on every other cycle
  always @(posedge hclk) begin
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  function automatic ach_bq frame(input logic [7:0] st, code,
      input ach_bq body);
    ach_bq f;
    logic [7:0] sum;
    f = {st, 8'h00, 8'(body.size() + 1), code};
    f = {f, body};
    sum = 8'(body.size() + 1) + code;
    foreach (body[i]) sum += body[i];
    f.push_back(8'h00 - sum);
    f.push_back(8'h03);
    return f;
  endfunction
  // Idle line shows the inverse so stale data never looks valid
  task automatic send(input ach_bq b);
    foreach (b[i]) begin
      rx_valid <= 1'b1;
      rx_data <= b[i];
      @(posedge hclk);
    end
    rx_valid <= 1'b0;
    rx_data <= ~b[b.size() - 1];
  endtask
endmodule
